// ==== rtl/pcd_mux_defs.vh ====
/*
 Constants for the port C/D alternate function override block.
 Assumes inclusion by bare name from design files.
*/
`ifndef PCD_MUX_DEFS_VH
`define PCD_MUX_DEFS_VH
`define PCD_PC_W            7
`define PCD_PD_W            8
`define PCD_RST_BIT         6
`define PCD_SCL_BIT         5
`define PCD_SDA_BIT         4
`define PCD_ADC_W           6
`define PCD_RXD_BIT         0
`define PCD_TXD_BIT         1
`define PCD_EXTI0_BIT       2
`define PCD_EXTI1_BIT       3
`define PCD_CMP2B_BIT       3
`define PCD_UCLK_BIT        4
`define PCD_CMP0B_BIT       5
`define PCD_CMP0A_BIT       6
`define PCD_SPIKE_NS        50
`define PCD_CLK_NS          8
`define PCD_PCINT_C_BASE    8
`define PCD_PCINT_D_BASE    16
`endif

// ==== rtl/pcd_spike_filter.v ====
/*
 Spike filter: output changes only after the input holds a new level
 for one more than the programmed number of cycles. Assumes one clock, async reset.
*/
`timescale 1ns/100ps
module pcd_spike_filter #(
    parameter CYCLES = 7,
    parameter CW     = 3
) (
    input  wire ref_clk,
    input  wire rst,
    input  wire din,
    output reg  dout
);
    reg [CW-1:0] count;

    // Count while input differs, reset count on agreement
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            count <= {CW{1'b0}};
            dout  <= 1'b1;
        end else if (din == dout) begin
            count <= {CW{1'b0}};
        end else if (count == CYCLES[CW-1:0]) begin
            count <= {CW{1'b0}};
            dout  <= din;
        end else begin
            count <= count + {{(CW-1){1'b0}}, 1'b1};
        end
    end
endmodule // pcd_spike_filter

// ==== rtl/pcd_mux.v ====
/*
 Port C and D alternate function override logic: combines port register
 values with peripheral override requests, registers the pin controls, and
 routes pin inputs to peripherals. Assumes all inputs synchronous to ref_clk.
*/
`timescale 1ns/100ps
`include "pcd_mux_defs.vh"
//
// Operation
// - Reset-disable fuse forces pull-up, input, digin
// - Two-wire enable drives bits 5,4 open drain
// - Two-wire pull-ups follow port bit and disable
// - Two-wire inputs pass through spike filters
// - Port C digin override from pin-change or analog
// - Pins map to pin-change sources 8 and 16
// - Timer0 compare A drives port D bit 6
// - Timer0 compare B drives port D bit 5
// - Timer2 compare B drives port D bit 3
// - Bits 5,4 feed timer1, timer0 count inputs
// - USART clock output overrides port D bit 4
// - Transmitter forces bit 1 output, no pull-up
// - Receiver forces bit 0 input, feeds receive data
// - Receiver pull-up follows port bit and disable
// - Ext interrupt 1 or pin-change keeps bit 3 digin
// - Ext interrupt 0 term uses group-1 enable
module pcd_mux #(
    parameter PC_W = `PCD_PC_W,
    parameter PD_W = `PCD_PD_W
) (
    input  wire            ref_clk,
    input  wire            rst,
    input  wire [PC_W-1:0] portc_output_reg,
    input  wire [PC_W-1:0] portc_direction,
    input  wire [PD_W-1:0] portd_output_reg,
    input  wire [PD_W-1:0] portd_direction,
    input  wire [PC_W-1:0] portc_pin_in,
    input  wire [PD_W-1:0] portd_pin_in,
    input  wire            global_pullup_disable,
    input  wire            reset_pin_disable_fuse,
    input  wire            two_wire_enable,
    input  wire            two_wire_clock_out,
    input  wire            two_wire_data_out,
    input  wire [5:0]      analog_digin_disable,
    input  wire            pin_change_group1_enable,
    input  wire            pin_change_group2_enable,
    input  wire [PC_W-1:0] pin_change_mask_c,
    input  wire [PD_W-1:0] pin_change_mask_d,
    input  wire            timer0_compare_a_enable,
    input  wire            timer0_compare_a_out,
    input  wire            timer0_compare_b_enable,
    input  wire            timer0_compare_b_out,
    input  wire            timer2_compare_b_enable,
    input  wire            timer2_compare_b_out,
    input  wire            usart_mode_select,
    input  wire            usart_ext_clock_out,
    input  wire            usart_transmit_enable,
    input  wire            usart_transmit_data,
    input  wire            usart_receive_enable,
    input  wire            ext_interrupt_0_enable,
    input  wire            ext_interrupt_1_enable,
    output reg  [PC_W-1:0] portc_pullup,
    output reg  [PC_W-1:0] portc_drive_enable,
    output reg  [PC_W-1:0] portc_drive_value,
    output reg  [PC_W-1:0] portc_digin_enable,
    output reg  [PD_W-1:0] portd_pullup,
    output reg  [PD_W-1:0] portd_drive_enable,
    output reg  [PD_W-1:0] portd_drive_value,
    output reg  [PD_W-1:0] portd_digin_enable,
    output reg             ext_reset_in,
    output reg             two_wire_clock_in,
    output reg             two_wire_data_in,
    output reg  [23:0]     pin_change_sources,
    output reg             timer0_count_input,
    output reg             timer1_count_input,
    output reg             usart_ext_clock_in,
    output reg             usart_receive_data,
    output reg             ext_interrupt_0,
    output reg             ext_interrupt_1
);
    localparam SPIKE_CYC = (`PCD_SPIKE_NS + `PCD_CLK_NS - 1) / `PCD_CLK_NS;

    reg  [PC_W-1:0] c_pu_en;
    reg  [PC_W-1:0] c_pu_val;
    reg  [PC_W-1:0] c_dd_en;
    reg  [PC_W-1:0] c_dd_val;
    reg  [PC_W-1:0] c_pv_en;
    reg  [PC_W-1:0] c_pv_val;
    reg  [PC_W-1:0] c_die_en;
    reg  [PC_W-1:0] c_die_val;
    reg  [PD_W-1:0] d_pu_en;
    reg  [PD_W-1:0] d_pu_val;
    reg  [PD_W-1:0] d_dd_en;
    reg  [PD_W-1:0] d_dd_val;
    reg  [PD_W-1:0] d_pv_en;
    reg  [PD_W-1:0] d_pv_val;
    reg  [PD_W-1:0] d_die_en;
    reg  [PD_W-1:0] d_die_val;
    reg  [PC_W-1:0] next_c_pu;
    reg  [PC_W-1:0] next_c_dd;
    reg  [PC_W-1:0] next_c_pv;
    reg  [PC_W-1:0] next_c_die;
    reg  [PD_W-1:0] next_d_pu;
    reg  [PD_W-1:0] next_d_dd;
    reg  [PD_W-1:0] next_d_pv;
    reg  [PD_W-1:0] next_d_die;
    wire [PC_W-1:0] c_pcm;
    wire [PD_W-1:0] d_pcm;
    wire [1:0]      tw_raw;
    wire [1:0]      tw_filt;
    wire [PC_W-1:0] c_pin_gated;
    wire [PD_W-1:0] d_pin_gated;
    genvar          gi;

    assign c_pcm = pin_change_mask_c & {PC_W{pin_change_group1_enable}};
    assign d_pcm = pin_change_mask_d & {PD_W{pin_change_group2_enable}};

    // Port C override sources
    always @* begin
        c_pu_en   = {PC_W{1'b0}};
        c_pu_val  = {PC_W{1'b0}};
        c_dd_en   = {PC_W{1'b0}};
        c_dd_val  = {PC_W{1'b0}};
        c_pv_en   = {PC_W{1'b0}};
        c_pv_val  = {PC_W{1'b0}};
        c_die_en  = c_pcm;
        c_die_val = c_pcm;
        c_die_en[`PCD_ADC_W-1:0] = c_pcm[`PCD_ADC_W-1:0] | analog_digin_disable;
        c_pu_en[`PCD_RST_BIT]   = reset_pin_disable_fuse;
        c_pu_val[`PCD_RST_BIT]  = 1'b1;
        c_dd_en[`PCD_RST_BIT]   = reset_pin_disable_fuse;
        c_die_en[`PCD_RST_BIT]  = reset_pin_disable_fuse | c_pcm[`PCD_RST_BIT];
        c_die_val[`PCD_RST_BIT] = reset_pin_disable_fuse;
        c_pu_en[`PCD_SCL_BIT]  = two_wire_enable;
        c_pu_en[`PCD_SDA_BIT]  = two_wire_enable;
        c_pu_val[`PCD_SCL_BIT] = portc_output_reg[`PCD_SCL_BIT] & ~global_pullup_disable;
        c_pu_val[`PCD_SDA_BIT] = portc_output_reg[`PCD_SDA_BIT] & ~global_pullup_disable;
        c_dd_en[`PCD_SCL_BIT]  = two_wire_enable;
        c_dd_en[`PCD_SDA_BIT]  = two_wire_enable;
        c_dd_val[`PCD_SCL_BIT] = two_wire_clock_out;
        c_dd_val[`PCD_SDA_BIT] = two_wire_data_out;
        c_pv_en[`PCD_SCL_BIT]  = two_wire_enable;
        c_pv_en[`PCD_SDA_BIT]  = two_wire_enable;
    end

    // Port D override sources
    always @* begin
        d_pu_en   = {PD_W{1'b0}};
        d_pu_val  = {PD_W{1'b0}};
        d_dd_en   = {PD_W{1'b0}};
        d_dd_val  = {PD_W{1'b0}};
        d_pv_en   = {PD_W{1'b0}};
        d_pv_val  = {PD_W{1'b0}};
        d_die_en  = d_pcm;
        d_die_val = {PD_W{1'b1}};
        d_pv_en[`PCD_CMP0A_BIT]  = timer0_compare_a_enable;
        d_pv_val[`PCD_CMP0A_BIT] = timer0_compare_a_out;
        d_pv_en[`PCD_CMP0B_BIT]  = timer0_compare_b_enable;
        d_pv_val[`PCD_CMP0B_BIT] = timer0_compare_b_out;
        d_pv_en[`PCD_UCLK_BIT]   = usart_mode_select;
        d_pv_val[`PCD_UCLK_BIT]  = usart_ext_clock_out;
        d_pv_en[`PCD_CMP2B_BIT]  = timer2_compare_b_enable;
        d_pv_val[`PCD_CMP2B_BIT] = timer2_compare_b_out;
        d_die_en[`PCD_EXTI1_BIT] = ext_interrupt_1_enable | d_pcm[`PCD_EXTI1_BIT];
        d_die_en[`PCD_EXTI0_BIT] = ext_interrupt_0_enable |
                                   (pin_change_mask_d[`PCD_EXTI0_BIT] & pin_change_group1_enable);
        d_pu_en[`PCD_TXD_BIT]  = usart_transmit_enable;
        d_dd_en[`PCD_TXD_BIT]  = usart_transmit_enable;
        d_dd_val[`PCD_TXD_BIT] = 1'b1;
        d_pv_en[`PCD_TXD_BIT]  = usart_transmit_enable;
        d_pv_val[`PCD_TXD_BIT] = usart_transmit_data;
        d_pu_en[`PCD_RXD_BIT]  = usart_receive_enable;
        d_pu_val[`PCD_RXD_BIT] = portd_output_reg[`PCD_RXD_BIT] & ~global_pullup_disable;
        d_dd_en[`PCD_RXD_BIT]  = usart_receive_enable;
    end

    // Port C override or normal value per attribute
    always @* begin
        next_c_pu  = (c_pu_en & c_pu_val) |
                     (~c_pu_en & portc_output_reg & ~portc_direction & {PC_W{~global_pullup_disable}});
        next_c_dd  = (c_dd_en & c_dd_val) | (~c_dd_en & portc_direction);
        next_c_pv  = (c_pv_en & c_pv_val) | (~c_pv_en & portc_output_reg);
        next_c_die = (c_die_en & c_die_val) | ~c_die_en;
    end

    // Port D override or normal value per attribute
    always @* begin
        next_d_pu  = (d_pu_en & d_pu_val) |
                     (~d_pu_en & portd_output_reg & ~portd_direction & {PD_W{~global_pullup_disable}});
        next_d_dd  = (d_dd_en & d_dd_val) | (~d_dd_en & portd_direction);
        next_d_pv  = (d_pv_en & d_pv_val) | (~d_pv_en & portd_output_reg);
        next_d_die = (d_die_en & d_die_val) | ~d_die_en;
    end

    assign c_pin_gated = portc_pin_in & next_c_die;
    assign d_pin_gated = portd_pin_in & next_d_die;
    assign tw_raw      = {portc_pin_in[`PCD_SCL_BIT], portc_pin_in[`PCD_SDA_BIT]};

    // Clock line on bit 1, data line on bit 0
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_tw_filter
            pcd_spike_filter #(
                .CYCLES (SPIKE_CYC),
                .CW     (3)
            ) u_filter (
                .ref_clk (ref_clk),
                .rst     (rst),
                .din     (tw_raw[gi]),
                .dout    (tw_filt[gi])
            );
        end
    endgenerate

    // Registered pin controls and peripheral inputs
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            portc_pullup       <= {PC_W{1'b0}};
            portc_drive_enable <= {PC_W{1'b0}};
            portc_drive_value  <= {PC_W{1'b0}};
            portc_digin_enable <= {PC_W{1'b0}};
            portd_pullup       <= {PD_W{1'b0}};
            portd_drive_enable <= {PD_W{1'b0}};
            portd_drive_value  <= {PD_W{1'b0}};
            portd_digin_enable <= {PD_W{1'b0}};
            ext_reset_in       <= 1'b1;
            two_wire_clock_in  <= 1'b1;
            two_wire_data_in   <= 1'b1;
            pin_change_sources <= 24'h000000;
            timer0_count_input <= 1'b0;
            timer1_count_input <= 1'b0;
            usart_ext_clock_in <= 1'b0;
            usart_receive_data <= 1'b1;
            ext_interrupt_0    <= 1'b0;
            ext_interrupt_1    <= 1'b0;
        end else begin
            portc_pullup       <= next_c_pu;
            portc_drive_enable <= next_c_dd;
            portc_drive_value  <= next_c_pv;
            portc_digin_enable <= next_c_die;
            portd_pullup       <= next_d_pu;
            portd_drive_enable <= next_d_dd;
            portd_drive_value  <= next_d_pv;
            portd_digin_enable <= next_d_die;
            ext_reset_in       <= reset_pin_disable_fuse | portc_pin_in[`PCD_RST_BIT];
            two_wire_clock_in  <= tw_filt[1];
            two_wire_data_in   <= tw_filt[0];
            pin_change_sources <= {d_pin_gated, 1'b0,
                                   c_pin_gated, {`PCD_PCINT_C_BASE{1'b0}}};
            timer0_count_input <= d_pin_gated[`PCD_UCLK_BIT];
            timer1_count_input <= d_pin_gated[`PCD_CMP0B_BIT];
            usart_ext_clock_in <= d_pin_gated[`PCD_UCLK_BIT];
            usart_receive_data <= d_pin_gated[`PCD_RXD_BIT];
            ext_interrupt_0    <= d_pin_gated[`PCD_EXTI0_BIT];
            ext_interrupt_1    <= d_pin_gated[`PCD_EXTI1_BIT];
        end
    end
endmodule // pcd_mux

// ==== tb/pcd_mux_sva.sv ====
/*
 Checker for the port C/D override block.
 Assumes binding to pcd_mux; sees its ports only.
*/
`timescale 1ns/100ps
module pcd_mux_sva #(
    parameter PC_W = 7,
    parameter PD_W = 8
) (
    input logic            ref_clk,
    input logic            rst,
    input logic [PC_W-1:0] portc_output_reg,
    input logic [PC_W-1:0] portc_pin_in,
    input logic [PD_W-1:0] portd_output_reg,
    input logic [PD_W-1:0] portd_direction,
    input logic            global_pullup_disable,
    input logic            reset_pin_disable_fuse,
    input logic            two_wire_enable,
    input logic            two_wire_clock_out,
    input logic            two_wire_data_out,
    input logic [5:0]      analog_digin_disable,
    input logic            pin_change_group1_enable,
    input logic [PC_W-1:0] pin_change_mask_c,
    input logic            timer0_compare_a_enable,
    input logic            timer0_compare_a_out,
    input logic            usart_transmit_enable,
    input logic            usart_transmit_data,
    input logic            usart_receive_enable,
    input logic [PC_W-1:0] portc_pullup,
    input logic [PC_W-1:0] portc_drive_enable,
    input logic [PC_W-1:0] portc_drive_value,
    input logic [PC_W-1:0] portc_digin_enable,
    input logic [PD_W-1:0] portd_pullup,
    input logic [PD_W-1:0] portd_drive_enable,
    input logic [PD_W-1:0] portd_drive_value,
    input logic [PD_W-1:0] portd_digin_enable,
    input logic            ext_reset_in,
    input logic            two_wire_clock_in
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire [5:0] dig_exp = (pin_change_mask_c[5:0] & {6{pin_change_group1_enable}}) | ~analog_digin_disable;
    wire [1:0] tw_pu   = portc_output_reg[5:4] & ~{2{global_pullup_disable}};
    property p_tx;
        !$past(rst) && $past(usart_transmit_enable) |-> portd_drive_enable[1] && !portd_pullup[1]
            && portd_drive_value[1] == $past(usart_transmit_data);
    endproperty
    a_tx: assert property (p_tx) else $error("transmit pin override wrong");
    property p_rx;
        !$past(rst) && $past(usart_receive_enable) |-> !portd_drive_enable[0]
            && portd_pullup[0] == ($past(portd_output_reg[0]) & !$past(global_pullup_disable));
    endproperty
    a_rx: assert property (p_rx) else $error("receive pin override wrong");
    property p_tw;
        !$past(rst) && $past(two_wire_enable) |-> portc_drive_value[5:4] == 2'h0
            && portc_drive_enable[5:4] == {$past(two_wire_clock_out), $past(two_wire_data_out)};
    endproperty
    a_tw: assert property (p_tw) else $error("two-wire drive wrong");
    property p_twpu;
        !$past(rst) && $past(two_wire_enable) |-> portc_pullup[5:4] == $past(tw_pu);
    endproperty
    a_twpu: assert property (p_twpu) else $error("two-wire pull-up wrong");
    property p_fuse;
        !$past(rst) && $past(reset_pin_disable_fuse) |-> portc_pullup[6] && !portc_drive_enable[6]
            && portc_digin_enable[6] && ext_reset_in;
    endproperty
    a_fuse: assert property (p_fuse) else $error("reset pin override wrong");
    property p_digc;
        !$past(rst) |-> portc_digin_enable[5:0] == $past(dig_exp);
    endproperty
    a_digc: assert property (p_digc) else $error("port C digital input wrong");
    property p_timer0_compare_a_out;
        !$past(rst) && $past(timer0_compare_a_enable) |-> portd_drive_value[6] == $past(timer0_compare_a_out)
            && portd_drive_enable[6] == $past(portd_direction[6]);
    endproperty
    a_timer0_compare_a_out: assert property (p_timer0_compare_a_out) else $error("compare A pin wrong");
    property p_digd;
        !$past(rst) |-> portd_digin_enable == {PD_W{1'b1}};
    endproperty
    a_digd: assert property (p_digd) else $error("port D digital input off");
    property p_filt;
        $changed(two_wire_clock_in) && !$past(rst, 10) |-> $past(portc_pin_in[5], 2) == two_wire_clock_in
            && $past(portc_pin_in[5], 7) == two_wire_clock_in;
    endproperty
    a_filt: assert property (p_filt) else $error("clock filter passed a short level");
endmodule // pcd_mux_sva

bind pcd_mux pcd_mux_sva #(.PC_W(PC_W), .PD_W(PD_W)) u_sva (.*);

// ==== tb/pcd_periph_model.sv ====
/*
 Peripheral sources: free-running patterns on all peripheral outputs.
 Assumes the block's clock and reset.
*/
`timescale 1ns/100ps
module pcd_periph_model (
    input  wire ref_clk,
    input  wire rst,
    output wire two_wire_clock_out,
    output wire two_wire_data_out,
    output wire timer0_compare_a_out,
    output wire timer0_compare_b_out,
    output wire timer2_compare_b_out,
    output wire usart_ext_clock_out,
    output wire usart_transmit_data
);
    reg [3:0] cnt;
    always @(posedge ref_clk or posedge rst) begin
        if (rst) cnt <= 4'h0;
        else cnt <= cnt + 4'h1;
    end
    assign two_wire_clock_out   = cnt[0];
    assign two_wire_data_out    = cnt[1];
    assign timer0_compare_a_out = cnt[2] ^ cnt[0];
    assign timer0_compare_b_out = cnt[1];
    assign timer2_compare_b_out = ~cnt[0];
    assign usart_ext_clock_out  = cnt[0];
    assign usart_transmit_data  = cnt[3] ^ cnt[1];
endmodule // pcd_periph_model

// ==== tb/pcd_mux_tb_top.sv ====
/*
 Testbench for the port C/D override block.
 Assumes peripheral model and bound checker.
*/
`timescale 1ns/100ps
module pcd_mux_tb_top;
    logic ref_clk, rst, global_pullup_disable, reset_pin_disable_fuse, two_wire_enable, usart_mode_select;
    logic pin_change_group1_enable, pin_change_group2_enable, ext_interrupt_0_enable, ext_interrupt_1_enable;
    logic timer0_compare_a_enable, timer0_compare_b_enable, timer2_compare_b_enable;
    logic usart_transmit_enable, usart_receive_enable;
    logic [6:0] portc_output_reg, portc_direction, portc_pin_in, pin_change_mask_c, pc_exp;
    logic [7:0] portd_output_reg, portd_direction, portd_pin_in, pin_change_mask_d;
    logic [5:0] analog_digin_disable, dexp;
    logic [6:0] pm;
    wire two_wire_clock_out, two_wire_data_out, timer0_compare_a_out, timer0_compare_b_out;
    wire timer2_compare_b_out, usart_ext_clock_out, usart_transmit_data, ext_reset_in, two_wire_clock_in;
    wire two_wire_data_in, timer0_count_input, timer1_count_input, usart_ext_clock_in, usart_receive_data;
    wire ext_interrupt_0, ext_interrupt_1;
    wire [6:0] portc_pullup, portc_drive_enable, portc_drive_value, portc_digin_enable;
    wire [7:0] portd_pullup, portd_drive_enable, portd_drive_value, portd_digin_enable;
    wire [23:0] pin_change_sources;
    int n_errors, cmp_count, n;

    pcd_mux uut (.*);
    pcd_periph_model u_pm (.*);

    task automatic chk(input string nm, input logic [23:0] got, input logic [23:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task step;
        @(posedge ref_clk);
        pm = {two_wire_clock_out, two_wire_data_out, timer0_compare_a_out, timer0_compare_b_out,
              timer2_compare_b_out, usart_ext_clock_out, usart_transmit_data};
        #1;
    endtask
    task wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task t_usart;
        portd_direction = 8'h01;
        portd_output_reg = 8'h13;
        {usart_transmit_enable, usart_receive_enable, usart_mode_select} = 3'h7;
        for (int i = 0; i < 4; i++) begin
            global_pullup_disable = i[1];
            portd_pin_in[0] = i[0];
            step;
            chk("serial dir", portd_drive_enable[1:0], 2'h2);
            chk("txd", {portd_drive_value[1], portd_pullup[1]}, {pm[0], 1'b0});
            chk("rxd pull", portd_pullup[0], !i[1]);
            chk("rxd", usart_receive_data, i[0]);
            chk("usart clock", portd_drive_value[4], pm[1]);
        end
        {usart_transmit_enable, usart_receive_enable, usart_mode_select} = 3'h0;
        step;
        chk("normal", {portd_drive_enable[1:0], portd_drive_value[4]}, 3'h3);
        $display("usart test done");
    endtask
    task t_timer;
        portd_direction = 8'h48;
        portd_output_reg = 8'h00;
        {timer0_compare_a_enable, timer0_compare_b_enable, timer2_compare_b_enable} = 3'h7;
        repeat (4) begin
            step;
            chk("compare", {portd_drive_value[6:5], portd_drive_value[3]}, pm[4:2]);
            chk("compare dir", portd_drive_enable, 8'h48);
        end
        {timer0_compare_a_enable, timer0_compare_b_enable, timer2_compare_b_enable} = 3'h0;
        $display("timer test done");
    endtask
    task t_twi;
        global_pullup_disable = 1'b0;
        portc_output_reg = 7'h20;
        portc_direction = 7'h30;
        two_wire_enable = 1'b1;
        repeat (3) begin
            step;
            chk("tw drive", {portc_drive_value[5:4], portc_drive_enable[5:4]}, {2'h0, pm[6:5]});
            chk("tw pull", portc_pullup[5:4], 2'h2);
        end
        global_pullup_disable = 1'b1;
        step;
        chk("tw pull off", portc_pullup[5:4], 2'h0);
        portc_pin_in[5] = 1'b0;
        repeat (3) step;
        portc_pin_in[5] = 1'b1;
        repeat (12) step;
        chk("glitch", two_wire_clock_in, 1'b1);
        portc_pin_in[5:4] = 2'h0;
        n = 0;
        while (two_wire_clock_in !== 1'b0 && n < 20) begin
            step;
            n++;
        end
        chk("filter delay", n, 9);
        chk("data filter", two_wire_data_in, 1'b0);
        two_wire_enable = 1'b0;
        $display("two-wire test done");
    endtask
    task t_fuse;
        portc_direction = 7'h40;
        portc_output_reg = 7'h00;
        portc_pin_in[6] = 1'b0;
        reset_pin_disable_fuse = 1'b1;
        step;
        chk("reset pin", {portc_pullup[6], portc_drive_enable[6], portc_digin_enable[6], ext_reset_in}, 4'hB);
        reset_pin_disable_fuse = 1'b0;
        step;
        chk("io pin", portc_drive_enable[6], 1'b1);
        chk("reset input", ext_reset_in, 1'b0);
        $display("fuse test done");
    endtask
    task t_digin;
        portc_pin_in = 7'h55;
        portd_pin_in = 8'hA5;
        {portd_direction, portd_output_reg} = 16'h0;
        {pin_change_mask_d, pin_change_group2_enable, ext_interrupt_0_enable, ext_interrupt_1_enable} = 11'h7FF;
        for (int i = 0; i < 8; i++) begin
            pin_change_mask_c = i[0] ? 7'h33 : 7'h0C;
            analog_digin_disable = i[1] ? 6'h3A : 6'h00;
            pin_change_group1_enable = i[2];
            dexp = (pin_change_mask_c[5:0] & {6{i[2]}}) | ~analog_digin_disable;
            pc_exp = 7'h55 & {1'b1, dexp};
            step;
            chk("digin c", portc_digin_enable[5:0], dexp);
            chk("sources c", pin_change_sources[14:8], pc_exp);
            chk("digin d", portd_digin_enable, 8'hFF);
        end
        chk("sources d", {pin_change_sources[23:15], pin_change_sources[7:0]}, {8'hA5, 9'h000});
        chk("routes", {timer1_count_input, timer0_count_input, usart_ext_clock_in, ext_interrupt_1,
                       ext_interrupt_0}, 5'h11);
        $display("digital input test done");
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    initial begin
        #10000;
        n_errors++;
        wrap_up;
    end
    initial begin
        rst = 1'b1;
        {global_pullup_disable, reset_pin_disable_fuse, two_wire_enable, pin_change_group1_enable,
         pin_change_group2_enable, usart_mode_select, timer0_compare_a_enable, timer0_compare_b_enable,
         timer2_compare_b_enable, usart_transmit_enable, usart_receive_enable, ext_interrupt_0_enable,
         ext_interrupt_1_enable} = 13'h0;
        {portc_output_reg, portc_direction, pin_change_mask_c, portd_output_reg, portd_direction,
         pin_change_mask_d, analog_digin_disable} = 51'h0;
        portc_pin_in = 7'h7F;
        portd_pin_in = 8'hFF;
        repeat (16) @(posedge ref_clk);
        #1 rst = 1'b0;
        t_usart;
        t_timer;
        t_twi;
        t_fuse;
        t_digin;
        wrap_up;
    end
endmodule // pcd_mux_tb_top
